/* verilog/gyro_output_defs.vh */
// constants for the gyro output and error report block
`ifndef GYRO_OUTPUT_DEFS_VH
`define GYRO_OUTPUT_DEFS_VH
// register indices (byte address = index * 4 not used; plain port)
`define REG_CTRL        4'h0
`define REG_FAULT_LO    4'h1
`define REG_FAULT_HI    4'h2
`define REG_STATUS      4'h3
`define REG_EXTERR_0    4'h4
`define REG_EXTERR_1    4'h5
`define REG_EXTERR_2    4'h6
`define REG_LATENCY     4'h7
`define REG_OUTPUT      4'h8
`define REG_SAMPLE      4'h9
`define REG_DIVIDER     4'hA
// control fields
`define CTRL_TRIG_EN    0
`define CTRL_CRLF       1
`define CTRL_UNIT_LSB   2
`define CTRL_UNIT_MSB   3
`define CTRL_RESET      32'h00000000
// output units
`define UNIT_RATE       2'h0
`define UNIT_INCR       2'h1
`define UNIT_AVG        2'h2
`define UNIT_INTEG      2'h3
// datagram
`define ID_NO_TERM      8'h2E
`define ID_CRLF         8'h2F
`define CRC_SEED        8'hFF
`define CRC_POLY        8'h07
`define STATUS_STARTUP  6
// timing
`define SAMPLE_NS       1000000
`define CLK_NS          10
`define SAMPLE_CYCLES   (`SAMPLE_NS / `CLK_NS)
`define STARTUP_MS      1000
`define STARTUP_SAMPLES (`STARTUP_MS)
`define US_NS           1000
`define US_CYCLES       7'h64
`define ID_DATAGRAMS    3
`define DIV_RESET       16'h0004
`endif

/* verilog/gyro_output_report.v */
// gyro output stage: extended error word, start-up, trigger, output units
//
// Behaviour
// - bits 59..57 axis config faults Z,Y,X; bit 56 self-test not running
// - bit 55 transmitter stuck; bits 54..52 axis data missing Z,Y,X
// - bits 51..47 buffer warnings; bit 46 flash check; bit 45 RAM check
// - per-axis lost, amplitude, comm, I/Q overflow in their own bits
// - bits 23..21 regulated, bit 20 supply, bits 19..17 references
// - bit 16 set while start-up stabilisation runs
// - bits 15..4 second comm, clipped, temp sensor, front-end temp
// - bit 3 controller temperature; bits 2..0 excitation frequency Z,Y,X
// - sampling and output continue normally during start-up
// - service-to-normal exit skips start-up
// - triggered mode sends only on a falling trigger edge
// - one datagram of latest data per trigger edge
// - three id datagrams always sent on leaving init
// - service mode answers commands regardless of trigger
// - latency counts from filtered sample to trigger edge
// - incremental sums samples times sample period since last send
// - average sends mean of samples since last send
// - integrated accumulates every sample times period since reset
// - integrated angle wraps silently in [-4, +4) degrees
// - datagram id 0x2E without, 0x2F with CR+LF
// - CRC-8 poly x^8+x^2+x+1 seed 0xFF over preceding bytes
// - rate output sends newest sample, dropping the rest
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "gyro_output_defs.vh"
module gyro_output_report #(
  parameter STARTUP_SAMPLES = `STARTUP_SAMPLES,
  parameter SAMPLE_CYCLES   = `SAMPLE_CYCLES
) (
  // clock and reset
  input  wire        clk,
  input  wire        srst,
  // register port
  input  wire [3:0]  regAddr,
  input  wire [31:0] regWrData,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [31:0] regRdData,
  // operating mode events
  input  wire        initDone,
  input  wire        serviceExit,
  input  wire        serviceMode,
  input  wire        commandValid,
  // sampled rate stream, one word per internal sample
  input  wire        sampleValid,
  input  wire [23:0] sampleRate,
  // external trigger pin
  input  wire        trigger,
  // datagram request toward the serial framer
  output wire        sendData,
  output wire        sendIdent,
  output wire        sendAnswer,
  output reg  [23:0] outData,
  output reg  [15:0] outLatency,
  output reg  [7:0]  outCrc,
  output reg         startupActive
);

////////////////////////////////////////////////////////////////////////////
// registers
reg  [31:0] ctrl;
reg  [31:0] faultLo;
reg  [31:0] faultHi;
reg  [15:0] divider;
wire        trigEn = ctrl[`CTRL_TRIG_EN];
wire        crlf   = ctrl[`CTRL_CRLF];
wire [1:0]  unit   = ctrl[`CTRL_UNIT_MSB:`CTRL_UNIT_LSB];

always @(posedge clk) begin
  if (srst) begin
    ctrl    <= `CTRL_RESET;
    faultLo <= 32'h00000000;
    faultHi <= 32'h00000000;
    divider <= `DIV_RESET;
  end else if (regWr) begin
    case (regAddr)
      `REG_CTRL:     ctrl    <= regWrData;
      `REG_FAULT_LO: faultLo <= regWrData;
      `REG_FAULT_HI: faultHi <= regWrData;
      `REG_DIVIDER:  divider <= regWrData[15:0];
      default: ;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////
// extended error word; fault sources are software-fed flags
wire [79:0] extErr;
assign extErr[79:60] = 20'h00000;
assign extErr[59:56] = faultHi[3:0];
assign extErr[55:52] = faultHi[7:4];
assign extErr[51:45] = faultHi[14:8];
assign extErr[44:42] = faultHi[17:15];
assign extErr[41:40] = 2'h0;
assign extErr[39:35] = faultHi[22:18];
assign extErr[34:33] = 2'h0;
assign extErr[32:28] = faultHi[27:23];
assign extErr[27:26] = 2'h0;
assign extErr[25:24] = faultHi[29:28];
assign extErr[23:17] = faultLo[22:16];
assign extErr[16]    = startupActive;
assign extErr[15:4]  = faultLo[15:4];
assign extErr[3:0]   = faultLo[3:0];

wire [7:0] statusByte = {1'b0, startupActive, 6'h00};

////////////////////////////////////////////////////////////////////////////
// start-up period, counted in internal samples
reg [15:0] startCount;
always @(posedge clk) begin
  if (srst) begin
    startupActive <= 1'b0;
    startCount    <= 16'h0000;
  end else if (serviceExit) begin
    startupActive <= 1'b0;
    startCount    <= 16'h0000;
  end else if (initDone) begin
    startupActive <= 1'b1;
    startCount    <= STARTUP_SAMPLES[15:0];
  end else if (startupActive && sampleValid) begin
    // outputs keep flowing meanwhile, only the flag waits
    if (startCount == 16'h0001)
      startupActive <= 1'b0;
    startCount <= startCount - 16'h0001;
  end
end

////////////////////////////////////////////////////////////////////////////
// identification datagrams on leaving init, ignoring trigger mode
reg [1:0] identLeft;
assign sendIdent = (identLeft != 2'h0);
always @(posedge clk) begin
  if (srst)
    identLeft <= 2'h0;
  else if (initDone)
    identLeft <= 2'd`ID_DATAGRAMS;
  else if (sendIdent)
    identLeft <= identLeft - 2'h1;
end

// command answers do not look at the trigger
assign sendAnswer = serviceMode & commandValid;

////////////////////////////////////////////////////////////////////////////
// trigger synchroniser and falling edge
reg trigMeta;
reg trigSync;
reg trigPrev;
always @(posedge clk) begin
  if (srst) begin
    trigMeta <= 1'b1;
    trigSync <= 1'b1;
    trigPrev <= 1'b1;
  end else begin
    trigMeta <= trigger;
    trigSync <= trigMeta;
    trigPrev <= trigSync;
  end
end
wire trigFall = trigPrev & ~trigSync;

////////////////////////////////////////////////////////////////////////////
// latency: microseconds since the last filtered sample
reg [6:0]  usDiv;
reg [15:0] latUs;
always @(posedge clk) begin
  if (srst || sampleValid) begin
    usDiv <= 7'h00;
    latUs <= 16'h0000;
  end else if (usDiv == `US_CYCLES - 7'h01) begin
    usDiv <= 7'h00;
    if (latUs != 16'hFFFF)
      latUs <= latUs + 16'h0001;
  end else begin
    usDiv <= usDiv + 7'h01;
  end
end

////////////////////////////////////////////////////////////////////////////
// continuous-mode pacing: one output per divider samples
reg [15:0] paceCount;
wire       paceHit = sampleValid && (paceCount + 16'h0001 >= divider);
always @(posedge clk) begin
  if (srst)
    paceCount <= 16'h0000;
  else if (paceHit)
    paceCount <= 16'h0000;
  else if (sampleValid)
    paceCount <= paceCount + 16'h0001;
end

wire inService = serviceMode;
assign sendData = ~inService & (trigEn ? trigFall : paceHit);

////////////////////////////////////////////////////////////////////////////
// accumulators; angle scale 2^-21 deg, rate 2^-14 deg/s, period 1 ms
// rate*1ms in angle lsb = rate * 128/1000, kept in a wide sum
wire signed [23:0] rateS = sampleRate;
reg  signed [39:0] rateSum;
reg  [15:0]        rateCnt;
reg  signed [23:0] lastRate;
reg  signed [39:0] integ;
wire signed [39:0] rateExt = {{16{rateS[23]}}, rateS};
wire signed [39:0] sumNow  = rateSum + rateExt;
wire [15:0]        cntNow  = rateCnt + 16'h0001;
// scaled by 128/1000: *16/125
function [23:0] toAngle;
  input signed [39:0] v;
  reg   signed [47:0] t;
  begin
    t = ($signed({{8{v[39]}}, v}) * 48'sd16) / 48'sd125;
    toAngle = t[23:0];
  end
endfunction

always @(posedge clk) begin
  if (srst) begin
    rateSum  <= 40'h0000000000;
    rateCnt  <= 16'h0000;
    lastRate <= 24'h000000;
    integ    <= 40'h0000000000;
  end else begin
    if (sampleValid) begin
      lastRate <= rateS;
      integ    <= integ + rateExt;
    end
    if (sendData) begin
      // a sample arriving now already went into this datagram
      rateSum <= 40'h0000000000;
      rateCnt <= 16'h0000;
    end else if (sampleValid) begin
      rateSum <= sumNow;
      rateCnt <= cntNow;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// output word, latency and CRC over id, three data bytes and status byte
// a sample landing in the send cycle is the newest, so it counts too
wire signed [39:0] curSum   = sampleValid ? sumNow : rateSum;
wire        [15:0] curCnt   = sampleValid ? cntNow : rateCnt;
wire signed [23:0] curRate  = sampleValid ? rateS : lastRate;
wire signed [39:0] integNow = sampleValid ? integ + rateExt : integ;
wire signed [39:0] curExt   = {{16{curRate[23]}}, curRate};
wire signed [39:0] avgWide  = (curCnt == 16'h0000) ? curExt :
                              curSum / $signed({24'h000000, curCnt});
reg [23:0] nextData;
always @* begin
  case (unit)
    `UNIT_RATE:  nextData = curRate;
    `UNIT_INCR:  nextData = toAngle(curSum);
    `UNIT_AVG:   nextData = avgWide[23:0];
    `UNIT_INTEG: nextData = toAngle(integNow);
    default:     nextData = curRate;
  endcase
end

function [7:0] crcByte;
  input [7:0] crc;
  input [7:0] b;
  integer i;
  reg [7:0] c;
  begin
    c = crc ^ b;
    for (i = 0; i < 8; i = i + 1)
      c = c[7] ? ((c << 1) ^ `CRC_POLY) : (c << 1);
    crcByte = c;
  end
endfunction

wire [7:0] idByte = crlf ? `ID_CRLF : `ID_NO_TERM;
wire [7:0] c0 = crcByte(`CRC_SEED, idByte);
wire [7:0] c1 = crcByte(c0, nextData[23:16]);
wire [7:0] c2 = crcByte(c1, nextData[15:8]);
wire [7:0] c3 = crcByte(c2, nextData[7:0]);

always @(posedge clk) begin
  if (srst) begin
    outData    <= 24'h000000;
    outLatency <= 16'h0000;
    outCrc     <= 8'h00;
  end else if (sendData) begin
    outData    <= nextData;
    outLatency <= latUs;
    outCrc     <= crcByte(c3, statusByte);
  end
end

////////////////////////////////////////////////////////////////////////////
// read port, data one cycle after the strobe
always @(posedge clk) begin
  if (srst)
    regRdData <= 32'h00000000;
  else if (regRd) begin
    case (regAddr)
      `REG_CTRL:     regRdData <= ctrl;
      `REG_FAULT_LO: regRdData <= faultLo;
      `REG_FAULT_HI: regRdData <= faultHi;
      `REG_STATUS:   regRdData <= {24'h000000, statusByte};
      `REG_EXTERR_0: regRdData <= extErr[31:0];
      `REG_EXTERR_1: regRdData <= extErr[63:32];
      `REG_EXTERR_2: regRdData <= {16'h0000, extErr[79:64]};
      `REG_LATENCY:  regRdData <= {16'h0000, latUs};
      `REG_OUTPUT:   regRdData <= {8'h00, outData};
      `REG_SAMPLE:   regRdData <= {8'h00, lastRate};
      `REG_DIVIDER:  regRdData <= {16'h0000, divider};
      default:       regRdData <= 32'h00000000;
    endcase
  end else
    regRdData <= 32'h00000000;
end

endmodule // gyro_output_report

/* test/gyro_host_model.sv */
// host side model: open-collector trigger driver and datagram counter
`timescale 1ns/1ps
module gyro_host_model (
  // clock and bench control
  input  wire       clk,
  input  wire       fire,
  // device pins
  input  wire       sendData,
  output reg        trigger,
  output reg  [7:0] dataCount
);
  initial begin
    trigger = 1'h1;
    dataCount = 8'h0;
  end
  // pin is pulled up, so it only goes low while the host pulls it
  always @(posedge clk) begin
    trigger <= !fire;
    if (sendData)
      dataCount <= dataCount + 8'h1;
  end
endmodule // gyro_host_model

/* test/gyro_output_assertions.sv */
// port assertions for the gyro output stage
`timescale 1ns/1ps
module gyro_output_assertions (
  // clock and reset
  input wire        clk,
  input wire        srst,
  // register writes and events
  input wire [3:0]  regAddr,
  input wire [31:0] regWrData,
  input wire        regWr,
  input wire        initDone,
  input wire        serviceExit,
  input wire        serviceMode,
  input wire        commandValid,
  input wire        sampleValid,
  input wire [23:0] sampleRate,
  input wire        trigger,
  // outputs
  input wire        sendData,
  input wire        sendAnswer,
  input wire [23:0] outData,
  input wire        startupActive
);
  reg  [3:0]  ctrl;
  reg  [23:0] last;
  wire [23:0] newest = sampleValid ? sampleRate : last;
  // mode bits shadowed from writes; the checker cannot see the register
  always @(posedge clk) begin
    if (srst) begin
      ctrl <= 4'h0;
      last <= 24'h0;
    end else begin
      if (regWr && regAddr == 4'h0)
        ctrl <= regWrData[3:0];
      if (sampleValid)
        last <= sampleRate;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  answer_cmd_a:
    assert property (sendAnswer == (serviceMode && commandValid))
    else $error("answer strobe wrong");
  trig_send_a:
    assert property ($fell(trigger) && ctrl[0] && !serviceMode
                     |-> ##2 sendData)
    else $error("no send after trigger edge");
  send_cause_a:
    assert property (sendData && ctrl[0]
                     |-> !$past(trigger, 2) && $past(trigger, 3))
    else $error("send without trigger edge");
  one_pulse_a:
    assert property (sendData |=> !sendData)
    else $error("send longer than one cycle");
  startup_rise_a:
    assert property (initDone |=> startupActive)
    else $error("start-up not entered");
  startup_hold_a:
    assert property (startupActive && !sampleValid && !serviceExit
                     |=> startupActive)
    else $error("start-up dropped early");
  service_skip_a:
    assert property (serviceExit && !initDone |=> !startupActive)
    else $error("start-up after service exit");
  rate_newest_a:
    assert property (sendData && ctrl[3:2] == 2'h0 |=> outData == $past(newest))
    else $error("rate output not newest sample");
endmodule // gyro_output_assertions
bind gyro_output_report gyro_output_assertions chk (
  .clk(clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .initDone(initDone), .serviceExit(serviceExit),
  .serviceMode(serviceMode), .commandValid(commandValid),
  .sampleValid(sampleValid), .sampleRate(sampleRate), .trigger(trigger),
  .sendData(sendData), .sendAnswer(sendAnswer), .outData(outData),
  .startupActive(startupActive));

/* test/gyro_output_and_error_report_bench.sv */
// self-checking bench for the gyro output stage
`timescale 1ns/1ps
module gyro_output_and_error_report_bench;
  reg          clk = 1'h0, srst = 1'h1, regWr = 1'h0, regRd = 1'h0;
  reg          initDone = 1'h0, serviceExit = 1'h0, serviceMode = 1'h0;
  reg          commandValid = 1'h0, sampleValid = 1'h0, fire = 1'h0;
  reg  [3:0]   regAddr = 4'h0;
  reg  [31:0]  regWrData = 32'h0;
  reg  [23:0]  sampleRate = 24'h0;
  wire [31:0]  regRdData;
  wire [23:0]  outData;
  wire [7:0]   outCrc, dataCount;
  wire         trigger, sendData, sendIdent, sendAnswer, startupActive;
  reg  [123:0] rows [0:2];
  reg  [123:0] row;
  integer      bad_count = 0, samples_checked = 0, i, n, cnt;
  gyro_output_report #(.STARTUP_SAMPLES(4)) uut (
    .clk(clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .initDone(initDone), .serviceExit(serviceExit),
    .serviceMode(serviceMode), .commandValid(commandValid),
    .sampleValid(sampleValid), .sampleRate(sampleRate), .trigger(trigger),
    .sendData(sendData), .sendIdent(sendIdent), .sendAnswer(sendAnswer),
    .outData(outData), .outLatency(), .outCrc(outCrc),
    .startupActive(startupActive));
  gyro_host_model host (.clk(clk), .fire(fire), .sendData(sendData),
    .trigger(trigger), .dataCount(dataCount));
  always #5 clk = ~clk;
  ////////////////////////////////////////
  function [7:0] crc8(input [39:0] m);
    reg [7:0] c;
    integer k;
    begin
      c = 8'hFF;
      for (k = 39; k >= 0; k = k - 1)
        c = {c[6:0], 1'h0} ^ ((c[7] ^ m[k]) ? 8'h07 : 8'h00);
      crc8 = c;
    end
  endfunction
  task check(input string what, input logic [31:0] exp, got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("mismatch %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'h1;
      @(posedge clk);
      regWr <= 1'h0;
      @(posedge clk);
    end
  endtask
  // read data stand only in the cycle after the strobe
  task rdck(input [3:0] a, input [31:0] e, input string what);
    begin
      regAddr <= a;
      regRd <= 1'h1;
      @(posedge clk);
      regRd <= 1'h0;
      #1 check(what, e, regRdData);
      @(posedge clk);
    end
  endtask
  task smp(input [23:0] v);
    begin
      sampleValid <= 1'h1;
      sampleRate <= v;
      @(posedge clk);
      sampleValid <= 1'h0;
      @(posedge clk);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    #100000 bad_count = bad_count + 1;
    give_verdict;
  end
  initial begin
    rows[0] = {4'h0, 24'h5, 24'h6, 24'h7, 24'h8, 24'h8};
    rows[1] = {4'h8, 24'h4, 24'h8, 24'hC, 24'h10, 24'hA};
    rows[2] = {4'h2, 24'h1, 24'h2, 24'h3, 24'h123456, 24'h123456};
    repeat (3) @(posedge clk);
    srst <= 1'h0;
    #1 check("reset", 0, {startupActive, sendData, outData});
    rdck(4'hA, 32'h4, "divider");
    rdck(4'hF, 32'h0, "unmapped");
    for (i = 0; i < 3; i = i + 1) begin
      row = rows[i];
      wr(4'h0, {28'h0, row[123:120]});
      cnt = dataCount;
      for (n = 0; n < 4; n = n + 1)
        smp(row[119 - 24 * n -: 24]);
      check("sends", cnt + 1, dataCount);
      check("data", row[23:0], outData);
      check("crc", crc8({7'h17, row[121], row[23:0], 8'h0}), outCrc);
    end
    wr(4'h2, 32'h3FFFFFFF);
    wr(4'h1, 32'h007FFFFF);
    rdck(4'h4, 32'hF3FEFFFF, "err low");
    rdck(4'h5, 32'h0FFFFCF9, "err mid");
    rdck(4'h6, 32'h0, "err high");
    wr(4'h2, 32'h0);
    wr(4'h1, 32'h0);
    initDone <= 1'h1;
    n = 0;
    repeat (8) begin
      #1 n = n + sendIdent;
      @(posedge clk);
      initDone <= 1'h0;
    end
    check("ident", 3, n);
    rdck(4'h3, 32'h40, "status");
    rdck(4'h4, 32'h10000, "err start");
    cnt = dataCount;
    for (n = 0; n < 4; n = n + 1)
      smp(24'h1);
    check("sends start", cnt + 1, dataCount);
    check("start end", 0, startupActive);
    initDone <= 1'h1;
    @(posedge clk);
    initDone <= 1'h0;
    serviceExit <= 1'h1;
    @(posedge clk);
    serviceExit <= 1'h0;
    repeat (2) @(posedge clk);
    check("svc exit", 0, startupActive);
    wr(4'h0, 32'h1);
    cnt = dataCount;
    for (n = 0; n < 4; n = n + 1)
      smp(24'h2);
    fire <= 1'h1;
    repeat (6) @(posedge clk);
    fire <= 1'h0;
    repeat (6) @(posedge clk);
    check("trig sends", cnt + 1, dataCount);
    check("trig data", 2, outData);
    serviceMode <= 1'h1;
    fire <= 1'h1;
    repeat (6) @(posedge clk);
    fire <= 1'h0;
    commandValid <= 1'h1;
    #1 check("answer", 1, sendAnswer);
    @(posedge clk);
    commandValid <= 1'h0;
    repeat (6) @(posedge clk);
    check("svc trig", cnt + 1, dataCount);
    give_verdict;
  end
endmodule // gyro_output_and_error_report_bench
